// file: dv/hdlc_engine_model.sv
/*
 Receive-side framing engine stand-in for controller one.
 Assumes the bench calls send, and ready depends on stored state only.
*/
`timescale 1ns/100ps
module hdlc_engine_model (
    input wire logic clock,
    input wire logic ready,
    output logic valid,
    output hdlc_fifo_pkg::rx_word_t word
);
    initial begin
        valid = 1'b0;
        word = '0;
    end
    // ==========================================================
    // offer one byte and hold it until taken
    task automatic send(input logic [7:0] d, input logic l, input logic [2:0] s);
        @(posedge clock);
        #1;
        valid = 1'b1;
        word = {d, l, s};
        while (ready !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        #1;
        valid = 1'b0;
        // a released word must not look like a held one
        word = ~word;
    endtask : send
endmodule : hdlc_engine_model

// file: dv/hdlc_fifo_host_interface_tb.sv
/*
 Register-port bench for the HDLC FIFO host interface.
 Assumes reads answer one cycle after the strobe; controller two idles.
*/
`timescale 1ns/100ps
module hdlc_fifo_host_interface_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [1:0] rx_in_ready;
    logic [1:0] tx_out_ready = 2'h0;
    logic [1:0] irq_pulse;
    logic [1:0][7:0] tx_data;
    logic [1:0] tx_valid;
    logic [1:0] tx_abort;
    logic [1:0] end_mark = 2'h0;
    logic [1:0] msg_done = 2'h0;
    logic valid0;
    hdlc_fifo_pkg::rx_word_t word0;
    int errors = 0;
    int n_compared = 0;
    int n_irq = 0;
    logic [7:0] got;
    logic [7:0] lens [4] = '{8'h04, 8'h04, 8'h04, 8'h02};
    logic [2:0] st [4] = '{3'h1, 3'h2, 3'h3, 3'h1};
    logic [7:0] ex [4] = '{8'h01, 8'h02, 8'h03, 8'h05};
    logic [7:0] msk [4] = '{8'h04, 8'h20, 8'h00, 8'h00};
    logic [7:0] nirq [4] = '{8'h01, 8'h02, 8'h02, 8'h02};

    hdlc_fifo_host_interface uut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_in_valid({1'b0, valid0}), .rx_in_word({12'h000, word0}),
        .rx_in_ready(rx_in_ready), .tx_out_valid(tx_valid), .tx_out_data(tx_data),
        .tx_out_ready(tx_out_ready), .tx_end_mark(end_mark), .tx_msg_done(msg_done),
        .tx_abort(tx_abort), .irq_pulse(irq_pulse));
    hdlc_engine_model eng (.clock(clock), .ready(rx_in_ready[0]), .valid(valid0),
        .word(word0));

    initial begin
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (irq_pulse[0] === 1'b1) begin
            n_irq <= n_irq + 1;
        end
    end
    // ==========================================================
    // register port tasks
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = ~w;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        got = reg_rdata;
    endtask : acc
    task automatic chk(input string n, input logic [7:0] e);
        n_compared++;
        if (got !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, got);
        end
    endtask : chk
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        acc(a, 8'h00, 1'b0);
        chk(n, e);
    endtask : rc
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // tests
    initial begin
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
        rc("info1", 8'h2E, 8'h28);
        rc("info2", 8'h2F, 8'h28);
        rc("event", 8'h2D, 8'h00);
        rc("free", 8'h9F, 8'h80);
        rc("unmapped", 8'h30, 8'h00);
        rc("rxcount", 8'h9C, 8'h00);
        $display("test reset done");
        // fill past full while stalled; the extra byte is dropped
        for (int i = 0; i < 129; i++) acc(8'h9D, i[7:0], 1'b1);
        rc("free", 8'h9F, 8'h00);
        rc("info1", 8'h2E, 8'h18);
        rc("txport", 8'h9D, 8'h00);
        tx_out_ready = 2'h1;
        // head byte stands until the next rising edge pops it
        for (int i = 0; i < 128; i++) begin
            @(negedge clock);
            got = tx_data[0];
            chk("txdata", i[7:0]);
        end
        repeat (2) @(negedge clock);
        got = {6'h00, tx_valid[0], tx_abort[0]};
        chk("abort", 8'h01);
        @(posedge clock);
        #1 tx_out_ready = 2'h0;
        rc("event", 8'h2D, 8'h02);
        rc("event", 8'h2D, 8'h00);
        rc("free", 8'h9F, 8'h80);
        $display("test tx done");
        for (int p = 0; p < 4; p++) begin
            acc(8'h21, msk[p], 1'b1);
            for (int i = 0; i < lens[p]; i++) eng.send(8'h40 + i[7:0], i == lens[p] - 1, st[p]);
            repeat (4) @(posedge clock);
            rc("rxcount", 8'h9C, lens[p]);
            rc("event", 8'h2D, 8'h01);
            for (int i = 0; i < lens[p]; i++) rc("rxdata", 8'h9E, 8'h40 + i[7:0]);
            rc("info1", 8'h2E, 8'h28 | ex[p]);
            got = n_irq[7:0];
            chk("irq", nirq[p]);
            $display("test packet %0d done", p);
        end
        acc(8'h21, 8'h40, 1'b1);
        acc(8'h9D, 8'h5A, 1'b1);
        got = tx_data[0];
        chk("txdata", 8'h5A);
        // marked end: an empty FIFO is no underrun
        end_mark = 2'h1;
        msg_done = 2'h1;
        tx_out_ready = 2'h1;
        @(posedge clock);
        #1 end_mark = 2'h0;
        msg_done = 2'h0;
        repeat (3) @(posedge clock);
        #1 tx_out_ready = 2'h0;
        rc("event", 8'h2D, 8'h00);
        got = n_irq[7:0];
        chk("irq", 8'h03);
        $display("test tx end done");
        // a packet longer than the FIFO ends in overrun
        for (int i = 0; i < 130; i++) eng.send(8'h40 + i[7:0], i == 129, 3'h1);
        repeat (4) @(posedge clock);
        rc("rxcount", 8'h9C, 8'hFF);
        for (int i = 0; i < 127; i++) rc("rxdata", 8'h9E, 8'h40 + i[7:0]);
        rc("rxcount", 8'h9C, 8'h01);
        rc("info1", 8'h2E, 8'h20);
        rc("rxdata", 8'h9E, 8'hBF);
        rc("info1", 8'h2E, 8'h2C);
        $display("test overrun done");
        give_verdict();
    end
    // hang guard, far beyond the expected run
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
endmodule : hdlc_fifo_host_interface_tb

// file: logic/hdlc_byte_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides and an occupancy count.
 Assumes one clock; the head word is visible while out_valid is high.
*/
`timescale 1ns/100ps
module hdlc_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int CW = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] cnt;
    } fifo_state_t;

    fifo_state_t q, d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // ==========================================================
    // control
    assign in_ready = q.cnt != CW'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = mem[q.rd_ptr];
    assign count = q.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.wr_ptr = (q.wr_ptr == LAST_PTR) ? '0 : q.wr_ptr + 1'b1;
        end
        if (pop) begin
            d.rd_ptr = (q.rd_ptr == LAST_PTR) ? '0 : q.rd_ptr + 1'b1;
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // storage carries no reset, only the pointers matter
    always_ff @(posedge clock) begin
        if (push) begin
            mem[q.wr_ptr] <= in_data;
        end
    end

endmodule : hdlc_byte_fifo

// file: logic/hdlc_fifo_host_interface.sv
/*
 Host-side FIFOs, packet status, event flags and interrupt requests for
 two HDLC controllers. Assumes the register port strobes come from port
 logic on this clock, and that the framing engines sit on the rx/tx sides.
*/
`timescale 1ns/100ps
module hdlc_fifo_host_interface #(
    parameter int DEPTH = hdlc_fifo_pkg::FIFO_DEPTH,
    parameter logic [7:0] TX_LOW_MARK = 8'h10,
    parameter logic [7:0] RX_HIGH_MARK = 8'h70
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [hdlc_fifo_pkg::NUM_CTL-1:0] rx_in_valid,
    input hdlc_fifo_pkg::rx_word_t [hdlc_fifo_pkg::NUM_CTL-1:0] rx_in_word,
    output logic [hdlc_fifo_pkg::NUM_CTL-1:0] rx_in_ready,
    output logic [hdlc_fifo_pkg::NUM_CTL-1:0] tx_out_valid,
    output logic [hdlc_fifo_pkg::NUM_CTL-1:0][7:0] tx_out_data,
    input wire logic [hdlc_fifo_pkg::NUM_CTL-1:0] tx_out_ready,
    input wire logic [hdlc_fifo_pkg::NUM_CTL-1:0] tx_end_mark,
    input wire logic [hdlc_fifo_pkg::NUM_CTL-1:0] tx_msg_done,
    output logic [hdlc_fifo_pkg::NUM_CTL-1:0] tx_abort,
    output logic [hdlc_fifo_pkg::NUM_CTL-1:0] irq_pulse
);
    localparam int NC = hdlc_fifo_pkg::NUM_CTL;
    localparam int CW = hdlc_fifo_pkg::CNT_W;
    localparam int RXW = $bits(hdlc_fifo_pkg::rx_word_t);
    localparam int RXE = $bits(hdlc_fifo_pkg::rx_entry_t);

    typedef struct packed {
        hdlc_fifo_pkg::rx_state_t rx_state;
        logic [7:0] pkt_len;
        logic pkt_big;
        logic [7:0] head_popped;
        hdlc_fifo_pkg::pkt_status_t pkt_status;
        logic msg_open;
        logic underrun;
        logic [hdlc_fifo_pkg::NUM_COND-1:0] cond_prev;
        logic irq;
        logic abort;
    } ctl_state_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic [NC-1:0][hdlc_fifo_pkg::NUM_MASK-1:0] mask;
        ctl_state_t [NC-1:0] ctl;
    } top_state_t;

    top_state_t q, d;

    logic [NC-1:0] sk_valid, sk_ready;
    hdlc_fifo_pkg::rx_word_t [NC-1:0] sk_word;
    logic [NC-1:0] rxf_in_valid, rxf_in_ready, rxf_out_valid, rxf_pop;
    hdlc_fifo_pkg::rx_entry_t [NC-1:0] rxf_in_data, rxf_head;
    logic [NC-1:0][CW-1:0] rxf_cnt, lenf_cnt, txf_cnt;
    logic [NC-1:0] lenf_in_valid, lenf_in_ready, lenf_pop;
    logic [NC-1:0][7:0] lenf_in_data, lenf_head;
    logic [NC-1:0] txf_in_valid;

    // ==========================================================
    // per-controller storage
    for (genvar c = 0; c < NC; c++) begin : g_ctl
        hdlc_pair_buffer #(.WIDTH(RXW)) u_rx_pair (
            .clock(clock), .rst(rst),
            .in_valid(rx_in_valid[c]), .in_ready(rx_in_ready[c]),
            .in_data(rx_in_word[c]),
            .out_valid(sk_valid[c]), .out_ready(sk_ready[c]),
            .out_data(sk_word[c])
        );
        hdlc_byte_fifo #(.WIDTH(RXE), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
            .clock(clock), .rst(rst),
            .in_valid(rxf_in_valid[c]), .in_ready(rxf_in_ready[c]),
            .in_data(rxf_in_data[c]),
            .out_valid(rxf_out_valid[c]), .out_ready(rxf_pop[c]),
            .out_data(rxf_head[c]), .count(rxf_cnt[c])
        );
        // one length per stored message end, so modular
        // subtraction gives the head message's remaining bytes
        hdlc_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_len_fifo (
            .clock(clock), .rst(rst),
            .in_valid(lenf_in_valid[c]), .in_ready(lenf_in_ready[c]),
            .in_data(lenf_in_data[c]),
            .out_valid(), .out_ready(lenf_pop[c]),
            .out_data(lenf_head[c]), .count(lenf_cnt[c])
        );
        hdlc_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
            .clock(clock), .rst(rst),
            .in_valid(txf_in_valid[c]), .in_ready(),
            .in_data(reg_wdata),
            .out_valid(tx_out_valid[c]), .out_ready(tx_out_ready[c]),
            .out_data(tx_out_data[c]), .count(txf_cnt[c])
        );
    end

    // ==========================================================
    // next state
    always_comb begin
        hdlc_fifo_pkg::rx_entry_t entry;
        logic [7:0] plen;
        logic [7:0] avail;
        logic [hdlc_fifo_pkg::NUM_COND-1:0] cond;
        logic push, underrun_evt, cont;
        logic [7:0] evt;
        entry = '0;
        plen = '0;
        avail = '0;
        cond = '0;
        push = 1'b0;
        underrun_evt = 1'b0;
        cont = 1'b0;
        evt = hdlc_fifo_pkg::REG_RESET;
        d = q;
        // unmapped reads return zero, not the last value
        if (reg_rd) begin
            d.rdata = hdlc_fifo_pkg::REG_RESET;
        end
        for (int c = 0; c < NC; c++) begin
            sk_ready[c] = 1'b0;
            rxf_in_valid[c] = 1'b0;
            lenf_in_valid[c] = 1'b0;
            rxf_pop[c] = 1'b0;
            lenf_pop[c] = 1'b0;
            txf_in_valid[c] = 1'b0;
            d.ctl[c].abort = 1'b0;
            plen = q.ctl[c].pkt_len + 8'h01;
            entry.data = sk_word[c].data;
            entry.first = q.ctl[c].rx_state == hdlc_fifo_pkg::RX_IDLE;
            entry.last = sk_word[c].last;
            entry.status = sk_word[c].status;
            if (entry.last && !q.ctl[c].pkt_big && plen <= hdlc_fifo_pkg::SHORT_MAX_BYTES
                && entry.status inside {hdlc_fifo_pkg::PKT_OK, hdlc_fifo_pkg::PKT_CRC_ERR}) begin
                entry.status = hdlc_fifo_pkg::PKT_TOO_SHORT;
            end
            if (rxf_cnt[c] == CW'(DEPTH - 1) && !entry.last) begin
                entry.last = 1'b1;
                entry.status = hdlc_fifo_pkg::PKT_OVERRUN;
            end
            rxf_in_data[c] = entry;
            lenf_in_data[c] = plen;
            push = 1'b0;
            if (q.ctl[c].rx_state == hdlc_fifo_pkg::RX_DISCARD) begin
                // rest of an overrun packet is dropped
                sk_ready[c] = 1'b1;
                if (sk_valid[c] && sk_word[c].last) begin
                    d.ctl[c].rx_state = hdlc_fifo_pkg::RX_IDLE;
                end
            end else begin
                sk_ready[c] = rxf_in_ready[c] && lenf_in_ready[c];
                push = sk_valid[c] && sk_ready[c];
                rxf_in_valid[c] = push;
                lenf_in_valid[c] = push && entry.last;
                if (push && entry.last) begin
                    d.ctl[c].pkt_len = 8'h00;
                    d.ctl[c].pkt_big = 1'b0;
                    d.ctl[c].rx_state = sk_word[c].last ? hdlc_fifo_pkg::RX_IDLE
                                                        : hdlc_fifo_pkg::RX_DISCARD;
                end else if (push) begin
                    d.ctl[c].pkt_len = plen;
                    d.ctl[c].pkt_big = q.ctl[c].pkt_big || plen > hdlc_fifo_pkg::SHORT_MAX_BYTES;
                    d.ctl[c].rx_state = hdlc_fifo_pkg::RX_IN_PKT;
                end
            end
            cond[0] = txf_cnt[c] != CW'(DEPTH);
            cond[1] = txf_cnt[c] < TX_LOW_MARK;
            cond[2] = rxf_out_valid[c];
            cond[3] = rxf_cnt[c] > RX_HIGH_MARK;
            d.ctl[c].cond_prev = cond;
            d.ctl[c].irq = |(cond & ~q.ctl[c].cond_prev
                             & q.mask[c][hdlc_fifo_pkg::NUM_COND-1:0]);
            if ((q.mask[c][hdlc_fifo_pkg::MSK_PKT_START] && push && entry.first)
                || (q.mask[c][hdlc_fifo_pkg::MSK_PKT_END] && push && entry.last)
                || (q.mask[c][hdlc_fifo_pkg::MSK_TX_END] && tx_msg_done[c])) begin
                d.ctl[c].irq = 1'b1;
            end
            underrun_evt = tx_out_ready[c] && !tx_out_valid[c] && q.ctl[c].msg_open;
            if (underrun_evt || tx_end_mark[c]) begin
                d.ctl[c].msg_open = 1'b0;
            end
            d.ctl[c].abort = underrun_evt;
            if (reg_wr && reg_addr == hdlc_fifo_pkg::OFF_TX_DATA[c]) begin
                txf_in_valid[c] = 1'b1;
                d.ctl[c].msg_open = 1'b1;
            end
            if (reg_wr && reg_addr == hdlc_fifo_pkg::OFF_IRQ_MASK[c]) begin
                d.mask[c] = reg_wdata[hdlc_fifo_pkg::NUM_MASK-1:0];
            end
            if (reg_rd && reg_addr == hdlc_fifo_pkg::OFF_EVENT_INFO) begin
                d.ctl[c].underrun = 1'b0;
            end
            if (underrun_evt) begin
                d.ctl[c].underrun = 1'b1;
            end
            if (reg_rd && reg_addr == hdlc_fifo_pkg::OFF_RX_DATA[c] && rxf_out_valid[c]) begin
                rxf_pop[c] = 1'b1;
                lenf_pop[c] = rxf_head[c].last;
                d.ctl[c].head_popped = rxf_head[c].last ? 8'h00 : q.ctl[c].head_popped + 8'h01;
                d.ctl[c].pkt_status = rxf_head[c].last ? rxf_head[c].status
                                                       : hdlc_fifo_pkg::PKT_IN_PROGRESS;
            end
            avail = (lenf_cnt[c] == '0) ? rxf_cnt[c] : lenf_head[c] - q.ctl[c].head_popped;
            // empty FIFO reads as the reset value
            cont = (lenf_cnt[c] == '0 && rxf_out_valid[c]) || avail > hdlc_fifo_pkg::RX_COUNT_MAX;
            if (avail > hdlc_fifo_pkg::RX_COUNT_MAX) begin
                avail = hdlc_fifo_pkg::RX_COUNT_MAX;
            end
            evt[hdlc_fifo_pkg::EVT_OPEN_BIT[c]] = rxf_out_valid[c] && rxf_head[c].first;
            evt[hdlc_fifo_pkg::EVT_UNDERRUN_BIT[c]] = q.ctl[c].underrun;
            if (reg_rd) begin
                if (reg_addr == hdlc_fifo_pkg::OFF_IRQ_MASK[c]) begin
                    d.rdata = {1'b0, q.mask[c]};
                end
                if (reg_addr == hdlc_fifo_pkg::OFF_PKT_INFO[c]) begin
                    d.rdata = hdlc_fifo_pkg::REG_RESET;
                    d.rdata[2:0] = q.ctl[c].pkt_status;
                    d.rdata[hdlc_fifo_pkg::INFO_RX_EMPTY] = !rxf_out_valid[c];
                    d.rdata[hdlc_fifo_pkg::INFO_TX_FULL] = txf_cnt[c] == CW'(DEPTH);
                    d.rdata[hdlc_fifo_pkg::INFO_TX_EMPTY] = !tx_out_valid[c];
                end
                if (reg_addr == hdlc_fifo_pkg::OFF_RX_COUNT[c]) begin
                    d.rdata = {cont, avail[6:0]};
                end
                if (reg_addr == hdlc_fifo_pkg::OFF_RX_DATA[c]) begin
                    d.rdata = rxf_out_valid[c] ? rxf_head[c].data : hdlc_fifo_pkg::REG_RESET;
                end
                if (reg_addr == hdlc_fifo_pkg::OFF_TX_FREE[c]) begin
                    d.rdata = CW'(DEPTH) - txf_cnt[c];
                end
                if (reg_addr == hdlc_fifo_pkg::OFF_TX_DATA[c]) begin
                    d.rdata = hdlc_fifo_pkg::REG_RESET;
                end
            end
        end
        if (reg_rd && reg_addr == hdlc_fifo_pkg::OFF_EVENT_INFO) begin
            d.rdata = evt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    for (genvar c = 0; c < NC; c++) begin : g_out
        assign irq_pulse[c] = q.ctl[c].irq;
        assign tx_abort[c] = q.ctl[c].abort;
    end

    // ==========================================================
    // checks on controller one
    property p_edge_irq;
        @(posedge clock) disable iff (rst)
        ($rose(txf_cnt[0] != CW'(DEPTH)) && q.mask[0][0]) |=> irq_pulse[0];
    endproperty
    a_edge_irq: assert property (p_edge_irq) else $error("missed edge interrupt");

    property p_masked;
        @(posedge clock) disable iff (rst)
        (q.mask[0] == '0) |=> !irq_pulse[0];
    endproperty
    a_masked: assert property (p_masked) else $error("masked interrupt seen");

    property p_status_pop;
        @(posedge clock) disable iff (rst)
        (rxf_pop[0] && rxf_head[0].last) |=> q.ctl[0].pkt_status == $past(rxf_head[0].status);
    endproperty
    a_status_pop: assert property (p_status_pop) else $error("status not updated");

    property p_overrun;
        @(posedge clock) disable iff (rst)
        (rxf_in_valid[0] && rxf_cnt[0] == CW'(DEPTH - 1))
            |-> rxf_in_data[0].last && (rxf_in_data[0].status == hdlc_fifo_pkg::PKT_OVERRUN
                || sk_word[0].last);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not reported");

    property p_rx_empty;
        @(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == hdlc_fifo_pkg::OFF_PKT_INFO[0])
            |=> reg_rdata[hdlc_fifo_pkg::INFO_RX_EMPTY] == !$past(rxf_out_valid[0]);
    endproperty
    a_rx_empty: assert property (p_rx_empty) else $error("empty flag wrong");

    property p_free;
        @(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == hdlc_fifo_pkg::OFF_TX_FREE[0])
            |=> reg_rdata == CW'(DEPTH) - $past(txf_cnt[0]);
    endproperty
    a_free: assert property (p_free) else $error("free count wrong");

    property p_underrun;
        @(posedge clock) disable iff (rst)
        (tx_out_ready[0] && !tx_out_valid[0] && q.ctl[0].msg_open)
            |=> tx_abort[0] && q.ctl[0].underrun ##1 !tx_abort[0];
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not flagged");

    property p_ms_open;
        @(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == hdlc_fifo_pkg::OFF_RX_COUNT[0] && lenf_cnt[0] == '0)
            |=> reg_rdata[hdlc_fifo_pkg::MS_BIT] == ($past(rxf_cnt[0]) != '0)
                && (reg_rdata[6:0] == $past(rxf_cnt[0][6:0])
                || $past(rxf_cnt[0]) > hdlc_fifo_pkg::RX_COUNT_MAX);
    endproperty
    a_ms_open: assert property (p_ms_open) else $error("receive count wrong");

endmodule : hdlc_fifo_host_interface

// file: logic/hdlc_fifo_pkg.sv
/*
 Constants, encodings and carrier types for the HDLC FIFO host interface.
 Assumes two controllers, a byte-wide register port and one system clock.
*/
// What this block does
// - FIFO condition masks: 0 blocks, 1 rising edge
// - packet event masks: 0 blocks, 1 allows
// - packet status bits 0-2, as of last read
// - status 0 progress, 1 ok, 2 checksum error
// - status 3 abort on seven ones
// - full receive FIFO ends packet, status overrun
// - status 5 when packet three bytes or fewer
// - info bit 3 live receive empty flag
// - info bit 4 tx full, bit 5 empty
// - opening byte flag, bits 0 and 2
// - underrun sends abort, sticky, clears on read
// - free transmit byte count; host honours it
// - receive count bits 0-6, up to 127
// - count bit 7: 1 continuing, 0 ends message
// - receive port gives one byte per read
// - transmit room while 128-byte FIFO not full
// - packet end event on completion or fault
package hdlc_fifo_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_CTL = 2;
    localparam int FIFO_DEPTH = 128;
    localparam int CNT_W = 8;
    localparam int NUM_COND = 4;
    localparam int NUM_MASK = 7;

    // ==========================================================
    // register offsets, index 0 is controller one
    localparam logic [7:0] OFF_EVENT_INFO = 8'h2D;
    localparam logic [NUM_CTL-1:0][7:0] OFF_IRQ_MASK = {8'h23, 8'h21};
    localparam logic [NUM_CTL-1:0][7:0] OFF_PKT_INFO = {8'h2F, 8'h2E};
    localparam logic [NUM_CTL-1:0][7:0] OFF_RX_COUNT = {8'hAC, 8'h9C};
    localparam logic [NUM_CTL-1:0][7:0] OFF_TX_DATA = {8'hAD, 8'h9D};
    localparam logic [NUM_CTL-1:0][7:0] OFF_RX_DATA = {8'hAE, 8'h9E};
    localparam logic [NUM_CTL-1:0][7:0] OFF_TX_FREE = {8'hAF, 8'h9F};
    localparam logic [7:0] REG_RESET = 8'h00;

    // ==========================================================
    // field positions
    localparam int MSK_PKT_START = 4;
    localparam int MSK_PKT_END = 5;
    localparam int MSK_TX_END = 6;
    localparam int INFO_RX_EMPTY = 3;
    localparam int INFO_TX_FULL = 4;
    localparam int INFO_TX_EMPTY = 5;
    localparam int MS_BIT = 7;
    localparam logic [NUM_CTL-1:0][2:0] EVT_OPEN_BIT = {3'h2, 3'h0};
    localparam logic [NUM_CTL-1:0][2:0] EVT_UNDERRUN_BIT = {3'h3, 3'h1};
    localparam logic [7:0] RX_COUNT_MAX = 8'h7F;
    localparam logic [7:0] SHORT_MAX_BYTES = 8'h03;

    // ==========================================================
    // encodings and carriers
    typedef enum logic [2:0] {
        PKT_IN_PROGRESS = 3'h0,
        PKT_OK = 3'h1,
        PKT_CRC_ERR = 3'h2,
        PKT_ABORT = 3'h3,
        PKT_OVERRUN = 3'h4,
        PKT_TOO_SHORT = 3'h5
    } pkt_status_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_IN_PKT = 2'h1,
        RX_DISCARD = 2'h3
    } rx_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
        pkt_status_t status;
    } rx_word_t;

    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic last;
        pkt_status_t status;
    } rx_entry_t;

endpackage : hdlc_fifo_pkg

// file: logic/hdlc_pair_buffer.sv
/*
 Two-entry buffer with valid/ready on both sides; full throughput, no loss.
 Assumes one clock; in_ready depends only on stored state.
*/
`timescale 1ns/100ps
module hdlc_pair_buffer #(
    parameter int WIDTH = 12
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic head;
        logic [1:0] cnt;
    } pair_state_t;

    pair_state_t q, d;
    logic push, pop;

    // ==========================================================
    // control
    assign in_ready = q.cnt != 2'h2;
    assign out_valid = q.cnt != 2'h0;
    assign out_data = q.slot[q.head];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.slot[q.head ^ q.cnt[0]] = in_data;
        end
        if (pop) begin
            d.head = ~q.head;
        end
        d.cnt = q.cnt + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : hdlc_pair_buffer
